/* verilog/counter_array_pkg.sv */
package counter_array_pkg;
   // special function register addresses
   localparam logic [7:0] ADDR_CTRL_STATUS  = 8'hd8;
   localparam logic [7:0] ADDR_MODE         = 8'hd9;
   localparam logic [7:0] ADDR_COUNT_LO     = 8'he9;
   localparam logic [7:0] ADDR_COUNT_HI     = 8'hf9;
   localparam logic [7:0] ADDR_MOD0_MODE    = 8'hda;
   localparam logic [7:0] ADDR_MOD1_MODE    = 8'hdb;
   localparam logic [7:0] ADDR_MOD2_MODE    = 8'hdc;
   localparam logic [7:0] ADDR_MOD0_LO      = 8'hfb;
   localparam logic [7:0] ADDR_MOD1_LO      = 8'hfd;
   localparam logic [7:0] ADDR_MOD2_LO      = 8'heb;
   localparam logic [7:0] ADDR_MOD0_HI      = 8'hfc;
   localparam logic [7:0] ADDR_MOD1_HI      = 8'hea;
   localparam logic [7:0] ADDR_MOD2_HI      = 8'hec;

   // control/status bit positions
   localparam int CS_OVF  = 7;
   localparam int CS_RUN  = 6;
   localparam int CS_MF2  = 2;
   // mode register bit positions
   localparam int MD_IDLE = 7;
   localparam int MD_WDON = 6;
   localparam int MD_LOCK = 5;
   localparam int MD_CPS_HI = 3;
   localparam int MD_CPS_LO = 1;
   localparam int MD_OVFIE = 0;
   // module mode register bit positions
   localparam int MM_PWM16 = 7;
   localparam int MM_ECOM  = 6;
   localparam int MM_MAT   = 3;
   localparam int MM_TOG   = 2;
   localparam int MM_PWM   = 1;
   localparam int MM_IE    = 0;

   localparam logic [7:0] CS_RESET    = 8'h00;
   localparam logic [7:0] CS_RD_MASK  = 8'hc7;
   localparam logic [7:0] MODE_RESET  = 8'h40;
   localparam logic [7:0] MODE_WR_MASK = 8'hef;
   localparam logic [7:0] MM_RESET    = 8'h00;
   localparam logic [7:0] SW_TIMER    = 8'h48;
   localparam logic [7:0] BYTE_MAX    = 8'hff;
   localparam logic [2:0] CPS_SYS_DIV12 = 3'h0;
   localparam logic [2:0] CPS_SYS_DIV4  = 3'h1;
   localparam logic [2:0] CPS_SYS       = 3'h4;
   localparam logic [3:0] DIV12_LAST  = 4'hb;
   localparam logic [3:0] DIV4_LAST   = 4'h3;
   localparam int NUM_MODULES = 3;
endpackage

/* verilog/counter_tick_gen.sv */
`timescale 1ns/100ps
module counter_tick_gen
   import counter_array_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] source_sel,
   input  wire logic       ext_tick,
   input  wire logic       enable,
   output logic            tick
);
   logic [3:0] div_reg;
   logic [3:0] div_last;

   always_comb begin
      div_last = (source_sel == CPS_SYS_DIV4) ? DIV4_LAST : DIV12_LAST;
   end

   // divider runs only while counting is allowed
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         div_reg <= 4'h0;
      end else if (div_reg >= div_last) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   always_comb begin
      case (source_sel)
         CPS_SYS_DIV12: tick = enable && (div_reg >= div_last);
         CPS_SYS_DIV4:  tick = enable && (div_reg >= div_last);
         CPS_SYS:       tick = enable;
         default:       tick = enable && ext_tick;
      endcase
   end
endmodule // counter_tick_gen

/* verilog/compare_module.sv */
`timescale 1ns/100ps
module compare_module
   import counter_array_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tick,
   input  wire logic [15:0] count,
   input  wire logic        low_wrap,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic        wr_mode,
   input  wire logic [7:0]  wdata,
   input  wire logic        force_timer,
   output logic [7:0]       mode_reg,
   output logic [15:0]      value_reg,
   output logic             match,
   output logic             pwm_out
);
   logic [15:0] value_next;
   logic        pwm_next;

   always_comb begin
      value_next = value_reg;
      if (wr_lo) begin
         value_next[7:0] = wdata;
      end
      if (wr_hi) begin
         value_next[15:8] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         value_reg <= 16'h0000;
      end else begin
         value_reg <= value_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= MM_RESET;
      end else if (force_timer) begin
         mode_reg <= SW_TIMER | (mode_reg & 8'h0001);
      end else if (wr_mode) begin
         mode_reg <= wdata;
      end else if (wr_lo) begin
         // R22 low write clears
         mode_reg[MM_ECOM] <= 1'b0;
      end else if (wr_hi) begin
         // R22 high write sets
         mode_reg[MM_ECOM] <= 1'b1;
      end
   end

   always_comb begin
      match = tick && mode_reg[MM_ECOM] && (count == value_reg);
   end

   always_comb begin
      pwm_next = pwm_out;
      if (!mode_reg[MM_ECOM]) begin
         // R2 zero duty
         pwm_next = 1'b0;
      end else if (mode_reg[MM_PWM] && mode_reg[MM_PWM16] && tick) begin
         // R1 sixteen bit duty
         if (count == 16'hffff) begin
            pwm_next = (value_reg == 16'h0000);
         end else if (count + 16'h0001 == value_reg) begin
            pwm_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= pwm_next;
      end
   end
endmodule // compare_module

/* verilog/counter_array_watchdog.sv */
// Overview of operation
// R1: 16-bit PWM duty equals (65536 minus compare value) over 65536.
// R2: compare enable cleared holds PWM output at zero duty.
// R3: module 2 watchdog resets system when updates come too late.
// R4: module 2 high byte compared to counter high; low byte is offset.
// R5: watchdog enabled after every reset.
// R6: watchdog enabled forces counter to run.
// R7: watchdog enabled ignores counter byte writes.
// R8: watchdog enabled freezes clock select and idle suspend bit.
// R9: watchdog enabled forces module 2 timer mode, blocks its mode writes.
// R10: run bit writes do not stop the counter while watchdog is on; run bit reads software value. Run bit starts and stops the counter while watchdog is off.
// R11: update write loads counter high plus offset, data discarded.
// R12: reset when low byte overflows while update equals counter high.
// R13: offset counts low byte overflows; first overflow within 256 clocks.
// R14: writing one to module 2 match flag forces immediate reset.
// R15: setting enable or lock bit enables watchdog.
// R16: lock holds watchdog until reset; else clearing enable disables.
// R17: reset gives divide-by-12 clock, zero low byte and offset.
// R18: software reconfigures: disable, clock, offset, idle, enable, update.
// R19: idle suspend bit stops counting during processor idle.
// R20: control/status resets zero; bits 5 to 3 read zero.
// R21: overflow and match flags set by hardware, interrupt, never auto-cleared.
// R22: compare low write clears enable; high write sets it.
`timescale 1ns/100ps
module counter_array_watchdog
   import counter_array_pkg::*;
#(
   parameter int NUM_MOD = NUM_MODULES
)(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic        SFR_WR,
   input  wire logic        SFR_RD,
   input  wire logic [7:0]  SFR_WDATA,
   input  wire logic        CPU_IDLE,
   input  wire logic        EXT_CLK_TICK,
   output logic [7:0]       SFR_RDATA,
   output logic             WATCHDOG_RESET,
   output logic             INTERRUPT_REQ,
   output logic [2:0]       PWM_OUT
);
   logic [7:0]  ctrl_reg;
   logic [7:0]  mode_reg;
   logic [15:0] count_reg;
   logic        idle_s1_reg;
   logic        idle_s2_reg;
   logic        ext_s1_reg;
   logic        ext_s2_reg;
   logic        ext_d_reg;
   logic        wd_on;
   logic        run_eff;
   logic        count_en;
   logic        tick;
   logic        low_wrap;
   logic        wr_ctrl;
   logic        wr_mode;
   logic        wr_lo;
   logic        wr_hi;
   logic        force_reset;
   logic        wd_expire;
   logic [7:0]  rdata_next;
   logic [2:0]  match_vec;
   logic [2:0]  pwm_vec;
   logic [7:0]  mm_mode [NUM_MODULES];
   logic [15:0] mm_value [NUM_MODULES];
   logic [7:0]  addr_mode [NUM_MODULES];
   logic [7:0]  addr_lo   [NUM_MODULES];
   logic [7:0]  addr_hi   [NUM_MODULES];
   logic [7:0]  update_next;

   assign addr_mode[0] = ADDR_MOD0_MODE;
   assign addr_mode[1] = ADDR_MOD1_MODE;
   assign addr_mode[2] = ADDR_MOD2_MODE;
   assign addr_lo[0]   = ADDR_MOD0_LO;
   assign addr_lo[1]   = ADDR_MOD1_LO;
   assign addr_lo[2]   = ADDR_MOD2_LO;
   assign addr_hi[0]   = ADDR_MOD0_HI;
   assign addr_hi[1]   = ADDR_MOD1_HI;
   assign addr_hi[2]   = ADDR_MOD2_HI;

   // pin synchronisers
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         idle_s1_reg <= 1'b0;
         idle_s2_reg <= 1'b0;
         ext_s1_reg  <= 1'b0;
         ext_s2_reg  <= 1'b0;
         ext_d_reg   <= 1'b0;
      end else begin
         idle_s1_reg <= CPU_IDLE;
         idle_s2_reg <= idle_s1_reg;
         ext_s1_reg  <= EXT_CLK_TICK;
         ext_s2_reg  <= ext_s1_reg;
         ext_d_reg   <= ext_s2_reg;
      end
   end

   // R15 enable or lock
   assign wd_on = mode_reg[MD_WDON] || mode_reg[MD_LOCK];

   always_comb begin
      wr_ctrl = SFR_WR && (SFR_ADDR == ADDR_CTRL_STATUS);
      wr_mode = SFR_WR && (SFR_ADDR == ADDR_MODE);
   end

   // R6 forced run
   assign run_eff = ctrl_reg[CS_RUN] || wd_on;
   // R19 idle suspend
   assign count_en = run_eff && !(mode_reg[MD_IDLE] && idle_s2_reg);

   counter_tick_gen u_tick (
      .clk        (CORE_CLK),
      .rst        (RST),
      .source_sel (mode_reg[MD_CPS_HI:MD_CPS_LO]),
      .ext_tick   (ext_s2_reg && !ext_d_reg),
      .enable     (count_en),
      .tick       (tick)
   );

   assign low_wrap = tick && (count_reg[7:0] == BYTE_MAX);

   // mode register
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         // R5 on after reset
         // R17 divide by twelve
         mode_reg <= MODE_RESET;
      end else if (wr_mode) begin
         if (wd_on) begin
            // R8 frozen fields
            mode_reg[MD_OVFIE] <= SFR_WDATA[MD_OVFIE];
            // R16 lock holds
            if (!mode_reg[MD_LOCK]) begin
               mode_reg[MD_WDON] <= SFR_WDATA[MD_WDON];
               mode_reg[MD_LOCK] <= SFR_WDATA[MD_LOCK];
            end else begin
               mode_reg[MD_WDON] <= mode_reg[MD_WDON] | SFR_WDATA[MD_WDON];
            end
         end else begin
            mode_reg <= SFR_WDATA & MODE_WR_MASK;
         end
      end
   end

   // counter
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         // R17 low byte zero
         count_reg <= 16'h0000;
      end else if (SFR_WR && !wd_on && (SFR_ADDR == ADDR_COUNT_LO)) begin
         count_reg[7:0] <= SFR_WDATA;
      end else if (SFR_WR && !wd_on && (SFR_ADDR == ADDR_COUNT_HI)) begin
         count_reg[15:8] <= SFR_WDATA;
      end else if (tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end
   // R7 writes ignored when on (above)

   // R11 update reload
   assign update_next = count_reg[15:8] + mm_value[2][7:0];

   generate
      for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
         logic lo_w;
         logic hi_w;
         logic md_w;
         logic [7:0] wd_data;
         assign lo_w = SFR_WR && (SFR_ADDR == addr_lo[m]);
         assign hi_w = SFR_WR && (SFR_ADDR == addr_hi[m]);
         // R9 mode writes blocked
         assign md_w = SFR_WR && (SFR_ADDR == addr_mode[m]) && !((m == 2) && wd_on);
         assign wd_data = ((m == 2) && wd_on && hi_w) ? update_next : SFR_WDATA;
         compare_module u_cmp (
            .clk         (CORE_CLK),
            .rst         (RST),
            .tick        (tick && !((m == 2) && wd_on)),
            .count       (count_reg),
            .low_wrap    (low_wrap),
            .wr_lo       (lo_w),
            .wr_hi       (hi_w),
            .wr_mode     (md_w),
            .wdata       (wd_data),
            // R9 forced timer
            .force_timer ((m == 2) && wd_on),
            .mode_reg    (mm_mode[m]),
            .value_reg   (mm_value[m]),
            .match       (match_vec[m]),
            .pwm_out     (pwm_vec[m])
         );
      end
   endgenerate

   // R14 forced reset
   assign force_reset = wd_on && wr_ctrl && SFR_WDATA[CS_MF2];
   // R3 R4 R12 R13 expiry on wrap with high match
   assign wd_expire = wd_on && low_wrap && (mm_value[2][15:8] == count_reg[15:8]);

   // control/status
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         // R20 reset zero
         ctrl_reg <= CS_RESET;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (wr_ctrl && CS_RD_MASK[i]) begin
               ctrl_reg[i] <= SFR_WDATA[i];
            end
         end
         // R10 run bit stored only
         // R21 hardware set wins
         if (low_wrap && count_reg[15:8] == BYTE_MAX) begin
            ctrl_reg[CS_OVF] <= 1'b1;
         end
         for (int i = 0; i < NUM_MODULES; i++) begin
            if (match_vec[i] || (i == 2 && wd_on && wr_ctrl && SFR_WDATA[CS_MF2])) begin
               ctrl_reg[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         WATCHDOG_RESET <= 1'b0;
      end else begin
         WATCHDOG_RESET <= force_reset || wd_expire;
      end
   end

   // R21 interrupt request
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         INTERRUPT_REQ <= 1'b0;
      end else begin
         INTERRUPT_REQ <= (ctrl_reg[CS_OVF] && mode_reg[MD_OVFIE])
                          || (ctrl_reg[0] && mm_mode[0][MM_IE])
                          || (ctrl_reg[1] && mm_mode[1][MM_IE])
                          || (ctrl_reg[2] && mm_mode[2][MM_IE]);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         PWM_OUT <= 3'h0;
      end else begin
         PWM_OUT <= pwm_vec;
      end
   end

   always_comb begin
      rdata_next = 8'h00;
      case (SFR_ADDR)
         // R20 unused read zero
         ADDR_CTRL_STATUS: rdata_next = ctrl_reg & CS_RD_MASK;
         ADDR_MODE:        rdata_next = mode_reg;
         ADDR_COUNT_LO:    rdata_next = count_reg[7:0];
         ADDR_COUNT_HI:    rdata_next = count_reg[15:8];
         ADDR_MOD0_MODE:   rdata_next = mm_mode[0];
         ADDR_MOD1_MODE:   rdata_next = mm_mode[1];
         ADDR_MOD2_MODE:   rdata_next = mm_mode[2];
         ADDR_MOD0_LO:     rdata_next = mm_value[0][7:0];
         ADDR_MOD1_LO:     rdata_next = mm_value[1][7:0];
         ADDR_MOD2_LO:     rdata_next = mm_value[2][7:0];
         ADDR_MOD0_HI:     rdata_next = mm_value[0][15:8];
         ADDR_MOD1_HI:     rdata_next = mm_value[1][15:8];
         ADDR_MOD2_HI:     rdata_next = mm_value[2][15:8];
         default:          rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         SFR_RDATA <= 8'h00;
      end else if (SFR_RD) begin
         SFR_RDATA <= rdata_next;
      end
   end
endmodule // counter_array_watchdog

/* verification/counter_array_watchdog_checker.sv */
`timescale 1ns/100ps
module counter_array_watchdog_checker
   import counter_array_pkg::*;
#(
   parameter int NUM_MOD = NUM_MODULES
)(
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic       SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic       CPU_IDLE,
   input wire logic       EXT_CLK_TICK,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       WATCHDOG_RESET,
   input wire logic       INTERRUPT_REQ,
   input wire logic [2:0] PWM_OUT
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic       on_reg;
   logic       lock_reg;
   logic       idle_reg;
   logic       armed_reg;
   logic [2:0] cps_reg;
   // watchdog state as written by software
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         on_reg   <= 1'b1;
         lock_reg <= 1'b0;
         idle_reg <= 1'b0;
         cps_reg  <= CPS_SYS_DIV12;
      end else if (SFR_WR && SFR_ADDR == ADDR_MODE) begin
         on_reg   <= lock_reg | SFR_WDATA[MD_WDON] | SFR_WDATA[MD_LOCK];
         lock_reg <= lock_reg | SFR_WDATA[MD_LOCK];
         if (!on_reg) begin
            idle_reg <= SFR_WDATA[MD_IDLE];
            cps_reg  <= SFR_WDATA[MD_CPS_HI:MD_CPS_LO];
         end
      end
   end
   // set once any module mode or compare high byte is written
   always_ff @(posedge CORE_CLK) begin
      if (RST)
         armed_reg <= 1'b0;
      else if (SFR_WR && (SFR_ADDR inside {ADDR_MOD0_MODE, ADDR_MOD1_MODE, ADDR_MOD2_MODE,
                                          ADDR_MOD0_HI, ADDR_MOD1_HI, ADDR_MOD2_HI}))
         armed_reg <= 1'b1;
   end
   property p_rst_quiet;
      $fell(RST) |-> !WATCHDOG_RESET && !INTERRUPT_REQ && PWM_OUT == 3'h0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
   property p_no_early;
      $fell(RST) ##0 (!SFR_WR)[*4] |=> !WATCHDOG_RESET[*4];
   endproperty
   a_no_early: assert property (p_no_early) else $error("watchdog reset right after reset");
   property p_force;
      SFR_WR && SFR_ADDR == ADDR_CTRL_STATUS && SFR_WDATA[CS_MF2] && on_reg |-> ##[1:2] WATCHDOG_RESET;
   endproperty
   a_force: assert property (p_force) else $error("forced watchdog reset missing");
   property p_off_no_force;
      SFR_WR && SFR_ADDR == ADDR_CTRL_STATUS && !on_reg |=> !WATCHDOG_RESET[*2];
   endproperty
   a_off_no_force: assert property (p_off_no_force) else $error("reset while watchdog off");
   property p_cs_unused;
      SFR_RD && SFR_ADDR == ADDR_CTRL_STATUS |=> SFR_RDATA[5:3] == 3'h0;
   endproperty
   a_cs_unused: assert property (p_cs_unused) else $error("unused status bits not zero");
   property p_mode_on;
      SFR_RD && SFR_ADDR == ADDR_MODE && !SFR_WR && !lock_reg |=> SFR_RDATA[MD_WDON] == $past(on_reg);
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("watchdog enable readback wrong");
   property p_frozen;
      SFR_RD && SFR_ADDR == ADDR_MODE && !SFR_WR |=>
         SFR_RDATA[MD_IDLE] == $past(idle_reg) && SFR_RDATA[MD_CPS_HI:MD_CPS_LO] == $past(cps_reg);
   endproperty
   a_frozen: assert property (p_frozen) else $error("clock select or idle bit changed");
   property p_pwm_idle;
      !armed_reg |-> PWM_OUT == 3'h0;
   endproperty
   a_pwm_idle: assert property (p_pwm_idle) else $error("pwm active without enable");
endmodule // counter_array_watchdog_checker

bind counter_array_watchdog counter_array_watchdog_checker #(.NUM_MOD(NUM_MOD)) u_checker (
   .CORE_CLK(CORE_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
   .SFR_WDATA(SFR_WDATA), .CPU_IDLE(CPU_IDLE), .EXT_CLK_TICK(EXT_CLK_TICK), .SFR_RDATA(SFR_RDATA),
   .WATCHDOG_RESET(WATCHDOG_RESET), .INTERRUPT_REQ(INTERRUPT_REQ), .PWM_OUT(PWM_OUT)
);

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench
   import counter_array_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       idle = 1'b0;
   logic [7:0] rdata;
   logic       wd_rst;
   logic       irq;
   logic [2:0] pwm;
   logic [7:0] v;
   int         n;
   int         n_errors = 0;
   int         checks_done = 0;
   int         cyc = 0;

   counter_array_watchdog dut (
      .CORE_CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata),
      .CPU_IDLE(idle), .EXT_CLK_TICK(1'b0), .SFR_RDATA(rdata), .WATCHDOG_RESET(wd_rst),
      .INTERRUPT_REQ(irq), .PWM_OUT(pwm)
   );

   always #20 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 32'h0000_4e20) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rng(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   // cycles until the watchdog pulse, or limit if none
   task automatic wait_pulse(input int limit, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (cnt < limit && wd_rst !== 1'b1);
   endtask

   task automatic pwm_high(output int cnt);
      cnt = 0;
      repeat (300) begin
         @(negedge clk);
         if (pwm[0] === 1'b1) cnt++;
      end
   endtask

   task automatic t_regs();
      do_reset();
      reg_rd(ADDR_CTRL_STATUS, v);
      chk(16'(v), 16'(CS_RESET));
      reg_rd(ADDR_MODE, v);
      chk(16'(v), 16'(MODE_RESET));
      reg_wr(ADDR_CTRL_STATUS, 8'h38);
      reg_rd(ADDR_CTRL_STATUS, v);
      chk(16'(v), 16'h0000);
      reg_wr(ADDR_COUNT_LO, 8'hf0);
      reg_rd(ADDR_COUNT_LO, v);
      chk(16'(v[7:4]), 16'h0000);
      reg_wr(ADDR_MOD2_MODE, 8'h42);
      reg_wr(ADDR_MODE, 8'hc8);
      reg_rd(ADDR_MODE, v);
      chk(16'(v), 16'(MODE_RESET));
      reg_wr(ADDR_MODE, 8'h00);
      reg_rd(ADDR_MOD2_MODE, v);
      chk(16'(v), 16'(SW_TIMER));
      reg_wr(ADDR_CTRL_STATUS, 8'h40);
      reg_rd(ADDR_CTRL_STATUS, v);
      chk(16'(v), 16'h0040);
   endtask

   task automatic t_force();
      do_reset();
      reg_wr(ADDR_CTRL_STATUS, 8'h04);
      wait_pulse(4, n);
      rng(n, 1, 3);
      reg_wr(ADDR_MODE, 8'h00);
      reg_wr(ADDR_CTRL_STATUS, 8'h04);
      wait_pulse(20, n);
      chk(16'(n), 16'h0014);
      reg_wr(ADDR_CTRL_STATUS, 8'h00);
      reg_wr(ADDR_MODE, 8'h20);
      reg_wr(ADDR_MODE, 8'h00);
      reg_wr(ADDR_CTRL_STATUS, 8'h04);
      wait_pulse(4, n);
      rng(n, 1, 3);
   endtask

   task automatic t_default();
      do_reset();
      wait_pulse(3200, n);
      rng(n, 3055, 3095);
   endtask

   task automatic t_offset();
      do_reset();
      reg_wr(ADDR_MODE, 8'h00);
      reg_wr(ADDR_MODE, 8'h08);
      reg_wr(ADDR_MOD2_LO, 8'h02);
      reg_wr(ADDR_MODE, 8'h48);
      reg_wr(ADDR_MOD2_HI, 8'h5a);
      wait_pulse(900, n);
      rng(n, 500, 775);
   endtask

   task automatic t_idle();
      do_reset();
      reg_wr(ADDR_MODE, 8'h00);
      reg_wr(ADDR_MODE, 8'h88);
      reg_wr(ADDR_MOD2_LO, 8'h01);
      reg_wr(ADDR_MODE, 8'hc8);
      idle <= 1'b1;
      reg_wr(ADDR_MOD2_HI, 8'h00);
      wait_pulse(700, n);
      chk(16'(n), 16'h02bc);
      @(posedge clk);
      idle <= 1'b0;
      wait_pulse(600, n);
      rng(n, 200, 530);
   endtask

   task automatic t_pwm();
      do_reset();
      reg_wr(ADDR_MODE, 8'h00);
      reg_wr(ADDR_MODE, 8'h08);
      reg_wr(ADDR_COUNT_LO, 8'h00);
      reg_wr(ADDR_COUNT_HI, 8'hff);
      reg_wr(ADDR_MOD0_MODE, 8'h83);
      reg_wr(ADDR_MOD0_LO, 8'h80);
      reg_wr(ADDR_MOD0_HI, 8'hff);
      reg_wr(ADDR_CTRL_STATUS, 8'h40);
      pwm_high(n);
      rng(n, 126, 130);
      chk(16'(irq), 16'h0001);
      reg_wr(ADDR_CTRL_STATUS, 8'h00);
      reg_wr(ADDR_COUNT_LO, 8'h00);
      reg_wr(ADDR_COUNT_HI, 8'hff);
      reg_wr(ADDR_MOD0_LO, 8'h80);
      reg_wr(ADDR_CTRL_STATUS, 8'h40);
      pwm_high(n);
      chk(16'(n), 16'h0000);
      chk(16'(irq), 16'h0000);
   endtask

   initial begin
      t_regs();
      t_force();
      t_default();
      t_offset();
      t_idle();
      t_pwm();
      test_done();
   end
endmodule // testbench
